// ==== rtl/dife_defines.vh ====
// Constants for the protection-information engine: register offsets,
// control field positions, operation codes, block lengths and CRC values.
// Assumes inclusion by bare name from the engine source.
`ifndef DIFE_DEFINES_VH
`define DIFE_DEFINES_VH

// Register byte offsets
`define DIFE_REG_CTRL 8'h00
`define DIFE_REG_SRC_REF 8'h04
`define DIFE_REG_DST_REF 8'h08
`define DIFE_REG_APP_SEED 8'h0c
`define DIFE_REG_APP_MASK 8'h10
`define DIFE_REG_XFER_LEN 8'h14
`define DIFE_REG_STATUS 8'h18
`define DIFE_REG_BYTES_DONE 8'h1c
`define DIFE_REG_FIN_SRC_REF 8'h20
`define DIFE_REG_FIN_DST_REF 8'h24
`define DIFE_REG_FIN_APP 8'h28

// Control register fields
`define DIFE_CTRL_START 0
`define DIFE_CTRL_OP_HI 3
`define DIFE_CTRL_OP_LO 1
`define DIFE_CTRL_BLK_HI 5
`define DIFE_CTRL_BLK_LO 4
`define DIFE_CTRL_CHK_GUARD 8
`define DIFE_CTRL_CHK_APP 9
`define DIFE_CTRL_CHK_REF 10
`define DIFE_CTRL_SRC_REF_INC 11
`define DIFE_CTRL_SRC_APP_INC 12
`define DIFE_CTRL_DST_REF_INC 13
`define DIFE_CTRL_DST_APP_INC 14
`define DIFE_CTRL_REF_PASS 15
`define DIFE_CTRL_APP_PASS 16
`define DIFE_CTRL_INV_SEED 17
`define DIFE_CTRL_INV_RESULT 18
`define DIFE_CTRL_RESET 32'h0000_0000

// Operation codes
`define DIFE_OP_CHECK 3'h0
`define DIFE_OP_INSERT 3'h1
`define DIFE_OP_STRIP 3'h2
`define DIFE_OP_UPDATE 3'h3
`define DIFE_OP_GENERATE 3'h4

// Protection block data lengths, selected by the block field
`define DIFE_BLK_512 16'h0200
`define DIFE_BLK_520 16'h0208
`define DIFE_BLK_4096 16'h1000
`define DIFE_BLK_4104 16'h1008
`define DIFE_TRL_LEN 16'h0008

// Guard CRC generator without its top term, and seeds
`define DIFE_CRC_POLY 16'h8bb7
`define DIFE_CRC_SEED0 16'h0000
`define DIFE_CRC_SEED1 16'hffff

`endif

// ==== rtl/dife_engine.v ====
// Protection-information engine: per-block guard CRC, tag tracking and
// trailer check, strip, insert, update and generate over byte streams.
// Assumes a source that offers bytes in address order and a destination
// write port that accepts a byte in every cycle it is offered one.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dife_defines.vh"

module dife_engine #(
  parameter LEN_W = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Source byte stream
  input wire src_valid_i,
  input wire [7:0] src_data_i,
  output reg src_ready_o,
  // Destination write port
  output reg dst_valid_o,
  output reg [7:0] dst_data_o,
  output reg [LEN_W-1:0] dst_addr_o,
  // Status
  output reg busy_o,
  output reg done_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_DATA = 3'h1;
  localparam ST_TRL_IN = 3'h2;
  localparam ST_TRL_OUT = 3'h3;
  localparam ST_DONE = 3'h4;

  // Byte-serial CRC step, most significant bit first
  function [15:0] dife_crc8;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `DIFE_CRC_POLY : 16'h0000);
      end
      dife_crc8 = r;
    end
  endfunction

  // Seed decode, used at job start and again at every block boundary
  function [15:0] dife_seed;
    input inv;
    begin
      dife_seed = inv ? `DIFE_CRC_SEED1 : `DIFE_CRC_SEED0;
    end
  endfunction

  reg [31:0] ctrl;
  reg [31:0] src_ref_seed;
  reg [31:0] dst_ref_seed;
  reg [31:0] app_seed;
  reg [31:0] app_mask;
  reg [LEN_W-1:0] xfer_len;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] pos;
  reg [LEN_W-1:0] in_cnt;
  reg [LEN_W-1:0] bytes_done;
  reg [15:0] crc;
  reg [55:0] trl;
  reg [31:0] s_ref;
  reg [31:0] d_ref;
  reg [15:0] s_app;
  reg [15:0] d_app;
  reg err_guard;
  reg err_app;
  reg err_ref;
  reg done_flag;
  reg [15:0] blen;
  reg next_ready;

  wire [2:0] op = ctrl[`DIFE_CTRL_OP_HI:`DIFE_CTRL_OP_LO];
  wire has_trl_in = (op == `DIFE_OP_CHECK) || (op == `DIFE_OP_STRIP) ||
                    (op == `DIFE_OP_UPDATE);
  wire writes_data = (op == `DIFE_OP_INSERT) || (op == `DIFE_OP_STRIP) ||
                     (op == `DIFE_OP_UPDATE);
  wire adv_src = has_trl_in;
  wire adv_dst = (op == `DIFE_OP_INSERT) || (op == `DIFE_OP_GENERATE) ||
                 (op == `DIFE_OP_UPDATE);
  wire take = src_valid_i && src_ready_o;
  wire start = reg_wr_i && (reg_addr_i == `DIFE_REG_CTRL) && reg_wdata_i[`DIFE_CTRL_START];
  wire data_last = (pos == blen - 16'h0001);
  wire trl_last = (pos == `DIFE_TRL_LEN - 16'h0001);
  wire [15:0] src_mask = app_mask[15:0];
  wire [15:0] dst_mask = app_mask[31:16];
  wire [15:0] crc_seed = dife_seed(ctrl[`DIFE_CTRL_INV_SEED]);
  wire [15:0] guard_calc = crc ^ {16{ctrl[`DIFE_CTRL_INV_RESULT]}};
  wire [63:0] stored = {trl, src_data_i};
  // Stored guard compared with computed CRC; equal to a zero remainder when the result is not inverted
  wire bad_guard = ctrl[`DIFE_CTRL_CHK_GUARD] && (stored[63:48] != guard_calc);
  // Mask applied to both sides, so an all-ones mask never fails
  wire bad_app = ctrl[`DIFE_CTRL_CHK_APP] &&
                 ((stored[47:32] & ~src_mask) != (s_app & ~src_mask));
  wire bad_ref = ctrl[`DIFE_CTRL_CHK_REF] && (stored[31:0] != s_ref);
  wire any_bad = bad_guard || bad_app || bad_ref;
  // Outgoing trailer: guard, masked application tag, reference tag
  wire [63:0] out_trl = {guard_calc, d_app & ~dst_mask, d_ref};
  wire [5:0] sel = 6'd56 - {pos[2:0], 3'b000};
  wire [7:0] out_byte = out_trl[sel +: 8];
  wire pass_app = ctrl[`DIFE_CTRL_APP_PASS] && (pos[2:1] == 2'b01);
  wire pass_ref = ctrl[`DIFE_CTRL_REF_PASS] && pos[2];
  wire [LEN_W-1:0] in_next = in_cnt + {{(LEN_W-1){1'b0}}, 1'b1};
  wire [15:0] blk_in = has_trl_in ? (blen + `DIFE_TRL_LEN) : blen;

  always @* begin
    case (ctrl[`DIFE_CTRL_BLK_HI:`DIFE_CTRL_BLK_LO])
      2'h0: blen = `DIFE_BLK_512;
      2'h1: blen = `DIFE_BLK_520;
      2'h2: blen = `DIFE_BLK_4096;
      default: blen = `DIFE_BLK_4104;
    endcase
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          // An empty transfer finishes at once without touching the streams
          next_state = (xfer_len == {LEN_W{1'b0}}) ? ST_DONE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (take && data_last) begin
          next_state = has_trl_in ? ST_TRL_IN : ST_TRL_OUT;
        end
      end
      ST_TRL_IN: begin
        if (take && trl_last) begin
          next_state = (any_bad || in_next >= xfer_len) ? ST_DONE : ST_DATA;
        end
      end
      ST_TRL_OUT: begin
        if (trl_last) begin
          next_state = (in_cnt >= xfer_len) ? ST_DONE : ST_DATA;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    next_ready = (next_state == ST_DATA) || (next_state == ST_TRL_IN);
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl <= `DIFE_CTRL_RESET;
      src_ref_seed <= 32'h0000_0000;
      dst_ref_seed <= 32'h0000_0000;
      app_seed <= 32'h0000_0000;
      app_mask <= 32'h0000_0000;
      xfer_len <= {LEN_W{1'b0}};
      state <= ST_IDLE;
      pos <= 16'h0000;
      in_cnt <= {LEN_W{1'b0}};
      bytes_done <= {LEN_W{1'b0}};
      crc <= 16'h0000;
      trl <= 56'h0;
      s_ref <= 32'h0000_0000;
      d_ref <= 32'h0000_0000;
      s_app <= 16'h0000;
      d_app <= 16'h0000;
      err_guard <= 1'b0;
      err_app <= 1'b0;
      err_ref <= 1'b0;
      done_flag <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
      src_ready_o <= 1'b0;
      dst_valid_o <= 1'b0;
      dst_data_o <= 8'h00;
      dst_addr_o <= {LEN_W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      src_ready_o <= next_ready;
      busy_o <= (next_state != ST_IDLE);
      dst_valid_o <= 1'b0;
      done_o <= 1'b0;
      // Descriptor writes are ignored while busy so a running job stays consistent
      if (reg_wr_i && state == ST_IDLE) begin
        case (reg_addr_i)
          `DIFE_REG_CTRL: ctrl <= {reg_wdata_i[31:1], 1'b0};
          `DIFE_REG_SRC_REF: src_ref_seed <= reg_wdata_i;
          `DIFE_REG_DST_REF: dst_ref_seed <= reg_wdata_i;
          `DIFE_REG_APP_SEED: app_seed <= reg_wdata_i;
          `DIFE_REG_APP_MASK: app_mask <= reg_wdata_i;
          `DIFE_REG_XFER_LEN: xfer_len <= reg_wdata_i[LEN_W-1:0];
          default: ;
        endcase
      end
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `DIFE_REG_CTRL: reg_rdata_o <= ctrl;
          `DIFE_REG_SRC_REF: reg_rdata_o <= src_ref_seed;
          `DIFE_REG_DST_REF: reg_rdata_o <= dst_ref_seed;
          `DIFE_REG_APP_SEED: reg_rdata_o <= app_seed;
          `DIFE_REG_APP_MASK: reg_rdata_o <= app_mask;
          `DIFE_REG_XFER_LEN: reg_rdata_o <= xfer_len;
          `DIFE_REG_STATUS: reg_rdata_o <= {27'h0, err_ref, err_app, err_guard,
                                            done_flag, busy_o};
          `DIFE_REG_BYTES_DONE: reg_rdata_o <= bytes_done;
          `DIFE_REG_FIN_SRC_REF: reg_rdata_o <= s_ref;
          `DIFE_REG_FIN_DST_REF: reg_rdata_o <= d_ref;
          `DIFE_REG_FIN_APP: reg_rdata_o <= {d_app, s_app};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (start) begin
            s_ref <= src_ref_seed;
            d_ref <= dst_ref_seed;
            s_app <= app_seed[15:0];
            d_app <= app_seed[31:16];
            // Control fields land with the start write, so the seed comes from it
            crc <= dife_seed(reg_wdata_i[`DIFE_CTRL_INV_SEED]);
            pos <= 16'h0000;
            in_cnt <= {LEN_W{1'b0}};
            bytes_done <= {LEN_W{1'b0}};
            dst_addr_o <= {LEN_W{1'b0}};
            err_guard <= 1'b0;
            err_app <= 1'b0;
            err_ref <= 1'b0;
            done_flag <= 1'b0;
          end
        end
        ST_DATA: begin
          if (take) begin
            crc <= dife_crc8(crc, src_data_i);
            in_cnt <= in_next;
            pos <= data_last ? 16'h0000 : pos + 16'h0001;
            if (writes_data) begin
              dst_valid_o <= 1'b1;
              dst_data_o <= src_data_i;
            end
          end
          if (dst_valid_o) begin
            dst_addr_o <= dst_addr_o + {{(LEN_W-1){1'b0}}, 1'b1};
          end
        end
        ST_TRL_IN: begin
          if (dst_valid_o) begin
            dst_addr_o <= dst_addr_o + {{(LEN_W-1){1'b0}}, 1'b1};
          end
          if (take) begin
            trl <= stored[55:0];
            in_cnt <= in_next;
            pos <= trl_last ? 16'h0000 : pos + 16'h0001;
            // Check and strip write nothing here
            if (op == `DIFE_OP_UPDATE) begin
              dst_valid_o <= 1'b1;
              dst_data_o <= (pass_app || pass_ref) ? src_data_i : out_byte;
            end
            if (trl_last) begin
              if (any_bad) begin
                err_guard <= bad_guard;
                err_app <= bad_app;
                err_ref <= bad_ref;
              end else begin
                crc <= crc_seed;
                bytes_done <= bytes_done + {{(LEN_W-16){1'b0}}, blk_in};
                if (adv_src) begin
                  if (ctrl[`DIFE_CTRL_SRC_REF_INC]) s_ref <= s_ref + 32'h0000_0001;
                  if (ctrl[`DIFE_CTRL_SRC_APP_INC]) s_app <= s_app + 16'h0001;
                end
                if (adv_dst) begin
                  if (ctrl[`DIFE_CTRL_DST_REF_INC]) d_ref <= d_ref + 32'h0000_0001;
                  if (ctrl[`DIFE_CTRL_DST_APP_INC]) d_app <= d_app + 16'h0001;
                end
              end
            end
          end
        end
        ST_TRL_OUT: begin
          // Insert and generate emit the fresh trailer one byte a cycle
          dst_valid_o <= 1'b1;
          dst_data_o <= out_byte;
          if (dst_valid_o) begin
            dst_addr_o <= dst_addr_o + {{(LEN_W-1){1'b0}}, 1'b1};
          end
          pos <= trl_last ? 16'h0000 : pos + 16'h0001;
          if (trl_last) begin
            crc <= crc_seed;
            bytes_done <= bytes_done + {{(LEN_W-16){1'b0}}, blk_in};
            if (ctrl[`DIFE_CTRL_DST_REF_INC]) d_ref <= d_ref + 32'h0000_0001;
            if (ctrl[`DIFE_CTRL_DST_APP_INC]) d_app <= d_app + 16'h0001;
          end
        end
        ST_DONE: begin
          // The last byte still needs its address step before idle
          if (dst_valid_o) begin
            dst_addr_o <= dst_addr_o + {{(LEN_W-1){1'b0}}, 1'b1};
          end
          done_flag <= 1'b1;
          done_o <= 1'b1;
        end
        default: ;
      endcase
    end
  end

endmodule // dife_engine

// ==== test/dife_assertions.sv ====
// Port checker for the protection-information engine.
// Assumes a bind from the bench; sees only the engine's ports.
`timescale 1ns/1ps
`include "dife_defines.vh"
module dife_assertions #(
  parameter LEN_W = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // Streams and status
  input wire src_valid_i,
  input wire [7:0] src_data_i,
  input wire src_ready_o,
  input wire dst_valid_o,
  input wire [7:0] dst_data_o,
  input wire [LEN_W-1:0] dst_addr_o,
  input wire busy_o,
  input wire done_o
);
  reg [2:0] op_q;
  wire take = src_valid_i && src_ready_o;
  wire go = reg_wr_i && reg_addr_i == `DIFE_REG_CTRL && reg_wdata_i[0] && !busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Ports do not show the operation, so track it from the start write
  always @(posedge clk_i) begin
    if (!rst_b_i)
      op_q <= 3'h0;
    else if (go)
      op_q <= reg_wdata_i[3:1];
  end
  property p_rd_zero; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_busy_start; go |-> ##[1:2] busy_o; endproperty
  a_busy_start: assert property (p_busy_start) else $error("start not taken");
  property p_check_quiet; busy_o && op_q == `DIFE_OP_CHECK |-> !dst_valid_o; endproperty
  a_check_quiet: assert property (p_check_quiet) else $error("check wrote data");
  property p_ins_echo;
    take && op_q == `DIFE_OP_INSERT |=> dst_valid_o && dst_data_o == $past(src_data_i);
  endproperty
  a_ins_echo: assert property (p_ins_echo) else $error("insert lost a byte");
  property p_upd_len; take && op_q == `DIFE_OP_UPDATE |=> dst_valid_o; endproperty
  a_upd_len: assert property (p_upd_len) else $error("update length differs");
  property p_gen_trail;
    $rose(dst_valid_o) && op_q == `DIFE_OP_GENERATE |-> dst_valid_o[*8] ##1 !dst_valid_o;
  endproperty
  a_gen_trail: assert property (p_gen_trail) else $error("trailer not 8 bytes");
  property p_addr_step;
    dst_valid_o && $past(dst_valid_o) |-> dst_addr_o == $past(dst_addr_o) + 1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address skipped");
  property p_done_pulse; done_o |=> !done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_ready_busy; src_ready_o |-> busy_o; endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("input taken while idle");
  c_job: cover property (go ##[1:2] busy_o);
  c_done: cover property (done_o);
  c_trail: cover property (op_q == `DIFE_OP_GENERATE && $rose(dst_valid_o));
endmodule // dife_assertions

// ==== test/dife_source_model.sv ====
// Source memory model: offers stored bytes in address order.
// Assumes the bench fills mem and pulses rewind_i before each job.
`timescale 1ns/1ps
module dife_source_model (
  // Clock and control
  input wire clk_i,
  input wire rst_b_i,
  input wire rewind_i,
  input wire slow_i,
  input wire [15:0] len_i,
  // Byte stream
  input wire src_ready_i,
  output reg src_valid_o,
  output reg [7:0] src_data_o
);
  reg [7:0] mem [0:1055];
  reg [15:0] ptr;
  reg gap;
  wire [15:0] nxt = ptr + {15'h0000, src_valid_o && src_ready_i};
  always @(posedge clk_i) begin
    if (!rst_b_i || rewind_i) begin
      ptr <= 16'h0000;
      gap <= 1'b0;
      src_valid_o <= 1'b0;
      src_data_o <= 8'h00;
    end else begin
      ptr <= nxt;
      gap <= ~gap;
      // An offer is held until taken; trailers come big-endian from mem
      if (src_valid_o && !src_ready_i)
        src_valid_o <= 1'b1;
      else if (nxt < len_i && !(slow_i && gap)) begin
        src_valid_o <= 1'b1;
        src_data_o <= mem[nxt];
      end else begin
        // Idle line toggles so a stale byte is never mistaken for data
        src_valid_o <= 1'b0;
        src_data_o <= ~src_data_o;
      end
    end
  end
endmodule // dife_source_model

// ==== test/dife_engine_test.sv ====
// Bench for the engine: register, insert, generate, check, update, strip jobs.
// Assumes the source model and the checker are compiled beside it.
`timescale 1ns/1ps
`include "dife_defines.vh"
module dife_engine_test;
  reg clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [31:0] reg_wdata_i = 32'h0000_0000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg rewind = 1'b0;
  reg slow = 1'b0;
  reg [15:0] src_len = 16'h0000;
  wire [31:0] reg_rdata_o;
  wire src_valid, src_ready, dst_valid_o, busy_o, done_o;
  wire [7:0] src_data, dst_data_o;
  wire [31:0] dst_addr_o;
  reg [7:0] got [0:1055];
  reg [31:0] rv;
  integer n_fail = 0, tests_run = 0, n_dst = 0, cyc = 0, k;
  dife_engine u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .src_valid_i(src_valid), .src_data_i(src_data),
    .src_ready_o(src_ready), .dst_valid_o(dst_valid_o), .dst_data_o(dst_data_o),
    .dst_addr_o(dst_addr_o), .busy_o(busy_o), .done_o(done_o));
  dife_source_model u_src (.clk_i(clk_i), .rst_b_i(rst_b_i), .rewind_i(rewind),
    .slow_i(slow), .len_i(src_len), .src_ready_i(src_ready),
    .src_valid_o(src_valid), .src_data_o(src_data));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (dst_valid_o) begin
      got[dst_addr_o[10:0]] = dst_data_o;
      n_dst = n_dst + 1;
    end
    if (cyc == 12000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk(reg_rdata_o, exp);
    end
  endtask
  task desc(input [31:0] sref, input [31:0] dref, input [31:0] app, input [31:0] msk);
    begin
      wr(`DIFE_REG_SRC_REF, sref);
      wr(`DIFE_REG_DST_REF, dref);
      wr(`DIFE_REG_APP_SEED, app);
      wr(`DIFE_REG_APP_MASK, msk);
    end
  endtask
  function [15:0] crc(input [15:0] s, input integer base);
    integer i, b;
    reg [15:0] c;
    begin
      c = s;
      for (i = 0; i < 512; i = i + 1)
        for (b = 7; b >= 0; b = b - 1)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ u_src.mem[base + i][b]) ? `DIFE_CRC_POLY : 16'h0000);
      crc = c;
    end
  endfunction
  task put(input integer a, input [63:0] t);
    for (k = 0; k < 8; k = k + 1)
      u_src.mem[a + k] = t[63 - 8*k -: 8];
  endtask
  task trl(input integer a, input [63:0] t);
    for (k = 0; k < 8; k = k + 1)
      chk(got[a + k], t[63 - 8*k -: 8]);
  endtask
  task job(input [31:0] ctrl, input [15:0] len);
    integer i;
    begin
      @(posedge clk_i);
      rewind <= 1'b1;
      src_len <= len;
      n_dst = 0;
      @(posedge clk_i);
      rewind <= 1'b0;
      wr(`DIFE_REG_XFER_LEN, {16'h0000, len});
      for (i = 0; i < 1056; i = i + 1)
        got[i] = 8'hxx;
      wr(`DIFE_REG_CTRL, ctrl);
      @(negedge clk_i);
      chk(busy_o, 1'b1);
      i = 0;
      while (done_o !== 1'b1 && i < 3000) begin
        @(posedge clk_i);
        i = i + 1;
      end
      chk(done_o, 1'b1);
      repeat (2) @(posedge clk_i);
      chk(busy_o, 1'b0);
    end
  endtask
  task s_insert;
    begin
      desc(32'h0000_0000, 32'hffff_ffff, 32'h00ff_0000, 32'hff00_0000);
      slow <= 1'b1;
      // Insert, incrementing destination tags, stalling source
      job(32'h0000_6003, 16'h0400);
      slow <= 1'b0;
      chk(n_dst, 1040);
      for (k = 0; k < 1024; k = k + 1)
        chk(got[k + (k >= 512 ? 8 : 0)], u_src.mem[k]);
      trl(512, {crc(16'h0000, 0), 16'h00ff, 32'hffff_ffff});
      trl(1032, {crc(16'h0000, 512), 16'h0000, 32'h0000_0000});
      rd(`DIFE_REG_BYTES_DONE, 32'h0000_0400);
      rd(`DIFE_REG_FIN_DST_REF, 32'h0000_0001);
    end
  endtask
  task s_gen;
    begin
      desc(32'h0000_0000, 32'hcafe_0001, 32'h5a5a_0000, 32'h0000_0000);
      // Generate, inverted seed and result, fixed tags
      job(32'h0006_0009, 16'h0200);
      chk(n_dst, 8);
      trl(0, {~crc(16'hffff, 0), 16'h5a5a, 32'hcafe_0001});
      rd(`DIFE_REG_BYTES_DONE, 32'h0000_0200);
      rd(`DIFE_REG_FIN_DST_REF, 32'hcafe_0001);
    end
  endtask
  task s_check;
    begin
      put(512, {crc(16'h0000, 0), 16'hbeef, 32'h0000_0100});
      put(1032, {crc(16'h0000, 520), 16'hbeef, 32'h0000_0100});
      desc(32'h0000_0100, 32'h0000_0000, 32'h0000_1111, 32'h0000_ffff);
      // All checks on, incrementing source reference, second block wrong
      job(32'h0000_0f01, 16'h0410);
      chk(n_dst, 0);
      rd(`DIFE_REG_STATUS, 32'h0000_0012);
      rd(`DIFE_REG_BYTES_DONE, 32'h0000_0208);
      rd(`DIFE_REG_FIN_SRC_REF, 32'h0000_0101);
    end
  endtask
  task s_update;
    begin
      desc(32'h0000_0000, 32'h0000_0055, 32'h7777_0000, 32'h0000_0000);
      // Update with reference pass-through
      job(32'h0000_8007, 16'h0208);
      chk(n_dst, 520);
      for (k = 0; k < 512; k = k + 1)
        chk(got[k], u_src.mem[k]);
      trl(512, {crc(16'h0000, 0), 16'h7777, 32'h0000_0100});
    end
  endtask
  task s_strip;
    begin
      desc(32'h0000_0100, 32'h0000_0000, 32'h0000_beef, 32'h0000_0000);
      // Strip one block with guard, application and reference checks on
      job(32'h0000_0705, 16'h0208);
      chk(n_dst, 512);
      for (k = 0; k < 512; k = k + 1)
        chk(got[k], u_src.mem[k]);
      rd(`DIFE_REG_STATUS, 32'h0000_0002);
      rd(`DIFE_REG_BYTES_DONE, 32'h0000_0208);
      rd(`DIFE_REG_FIN_APP, 32'h0000_beef);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    for (k = 0; k < 1056; k = k + 1)
      u_src.mem[k] = k * 7 + 3;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`DIFE_REG_STATUS, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    s_insert;
    s_gen;
    s_check;
    s_update;
    s_strip;
    conclude;
  end
endmodule // dife_engine_test
bind dife_engine dife_assertions #(.LEN_W(LEN_W)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_valid_i(src_valid_i),
  .src_data_i(src_data_i), .src_ready_o(src_ready_o), .dst_valid_o(dst_valid_o),
  .dst_data_o(dst_data_o), .dst_addr_o(dst_addr_o), .busy_o(busy_o), .done_o(done_o));
